// ### flash_lock_pkg.sv
`default_nettype none
package flash_lock_pkg;
	// array geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int MEM_DEPTH = 4096;
	// parallel mode pins packed as {sel_c, sel_d, sel_e, sig_low_a, sig_low_b}
	localparam logic [4:0] MODE_WRITE_CODE = 5'h0f;
	localparam logic [4:0] MODE_READ_CODE = 5'h03;
	localparam logic [4:0] MODE_WRITE_LOCK1 = 5'h1f;
	localparam logic [4:0] MODE_WRITE_LOCK2 = 5'h1c;
	localparam logic [4:0] MODE_WRITE_LOCK3 = 5'h16;
	localparam logic [4:0] MODE_READ_LOCK = 5'h1a;
	localparam logic [4:0] MODE_CHIP_ERASE = 5'h14;
	localparam logic [4:0] MODE_SIGNATURE = 5'h00;
	// lock bit readback positions on the data lines
	localparam int LOCK_RD_POS = 2;
	// signature locations
	localparam logic [11:0] SIG_ADDR_MAKER = 12'h000;
	localparam logic [11:0] SIG_ADDR_DEV_A = 12'h100;
	localparam logic [11:0] SIG_ADDR_DEV_B = 12'h200;
	// serial instruction encodings
	localparam logic [7:0] SER_OP_SPECIAL = 8'hac;
	localparam logic [7:0] SER_ENABLE_B2 = 8'h53;
	localparam logic [7:0] SER_ENABLE_ECHO = 8'h69;
	localparam logic [2:0] SER_ERASE_B2_TOP = 3'h4;
	localparam logic [5:0] SER_LOCK_B2_TOP = 6'h38;
	localparam logic [7:0] SER_OP_READ = 8'h20;
	localparam logic [7:0] SER_OP_WRITE = 8'h40;
	// answers with no live data behind them
	localparam logic [7:0] ERASE_READ_VALUE = 8'h00;
	localparam logic [7:0] ERASED_VALUE = 8'hff;
	localparam logic [7:0] BLOCKED_READ_VALUE = 8'hff;
	// reset values
	localparam logic [2:0] LOCK_RESET = 3'h0;
	// timing, printed figures in ns, counts at the 4 ns ref_clk
	localparam int CLK_PERIOD_NS = 4;
	localparam int PAR_WRITE_NS = 50000;
	localparam int SER_WRITE_NS = 500000;
	localparam int ERASE_NS = 500000000;
	localparam int PAR_WRITE_CYCLES = PAR_WRITE_NS / CLK_PERIOD_NS;
	localparam int SER_WRITE_CYCLES = SER_WRITE_NS / CLK_PERIOD_NS;
	localparam int ERASE_CYCLES = ERASE_NS / CLK_PERIOD_NS;
	localparam int TIMER_W = 27;
endpackage
`default_nettype wire

// ### serial_link_shifter.sv
`default_nettype none
// link-side shifter: runs on the programmer's shift clock only
module serial_link_shifter
	import flash_lock_pkg::*;
(
	input wire logic sck,
	input wire logic rst_n,
	input wire logic mosi,
	input wire logic [7:0] reply_byte,
	output logic miso,
	output logic [23:0] head_word,
	output logic head_toggle,
	output logic [31:0] full_word,
	output logic full_toggle
);
	logic [30:0] shift_in;
	logic [4:0] bit_cnt;

	// sample on the rising edge, msb first; framing relies on the host counting 32 bits
	always_ff @(posedge sck or negedge rst_n) begin
		if (!rst_n) begin
			shift_in <= 31'h0;
			bit_cnt <= 5'h0;
			head_word <= 24'h0;
			head_toggle <= 1'b0;
			full_word <= 32'h0;
			full_toggle <= 1'b0;
		end else begin
			shift_in <= {shift_in[29:0], mosi};
			bit_cnt <= bit_cnt + 5'h1;
			if (bit_cnt == 5'h17) begin
				head_word <= {shift_in[22:0], mosi};
				head_toggle <= ~head_toggle;
			end
			if (bit_cnt == 5'h1f) begin
				full_word <= {shift_in, mosi};
				full_toggle <= ~full_toggle;
			end
		end
	end

	// drive on the falling edge; reply_byte is held by the core for the whole fourth byte,
	// and the shift clock limit leaves it at least eight core cycles to settle
	always_ff @(negedge sck or negedge rst_n) begin
		if (!rst_n) begin
			miso <= 1'b0;
		end else if (bit_cnt[4:3] == 2'h3) begin
			miso <= reply_byte[3'h7 - bit_cnt[2:0]];
		end else begin
			miso <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### flash_program_lock_interface.sv
`default_nettype none
// How it works
// - three lock bits, all clear means no protection
// - lock one blocks table reads and programming
// - locks one two block verify; all three block external
// - lock one latches external access pin at reset
// - parallel byte write self-timed, 50 us max
// - busy read of last byte inverts bit seven
// - progress output low after strobe, high when done
// - verify unless locks one, two both set
// - signature bytes at three fixed locations
// - serial erase self-timed about 500 ms
// - serial reads during erase return zero
// - erase sets every byte to ff
// - serial needs session reset and enable first
// - serial byte writes self-timed, reads return data
// - session ends when reset goes low
// - serial busy read inverts msb
// - every serial instruction is four bytes
// - enable encoding ac 53, echo 69
// - erase encoding ac then 100x xxxx
module flash_program_lock_interface
	import flash_lock_pkg::*;
#(
	parameter int PAR_WRITE_TIME = PAR_WRITE_CYCLES,
	parameter int SER_WRITE_TIME = SER_WRITE_CYCLES,
	parameter int ERASE_TIME = ERASE_CYCLES,
	parameter logic [7:0] MAKER_CODE = 8'ha5, // arbitrary value
	parameter logic [7:0] DEVICE_CODE_A = 8'h3c, // arbitrary value
	parameter logic [7:0] DEVICE_CODE_B = 8'h7e // arbitrary value
)(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic session_reset,
	input wire logic [11:0] address_in,
	input wire logic [7:0] data_in,
	input wire logic mode_sel_c,
	input wire logic mode_sel_d,
	input wire logic mode_sel_e,
	input wire logic signature_select_low_a,
	input wire logic signature_select_low_b,
	input wire logic external_access_high_voltage_pin,
	input wire logic latch_enable_program_strobe,
	input wire logic sck,
	input wire logic mosi,
	output logic [7:0] data_out,
	output logic data_oe,
	output logic program_progress_output,
	output logic miso,
	output logic [2:0] lock_state,
	output logic table_read_block,
	output logic verify_block,
	output logic external_exec_block,
	output logic external_access_latched
);
	localparam int SYNC_W = 30;
	localparam logic [SYNC_W-1:0] SYNC_RESET = 30'h0000_0004; // strobe idles high
	logic [SYNC_W-1:0] pin_s1, pin_s2;
	logic [4:0] s_mode;
	logic s_hv, s_strobe, s_session, s_ea, strobe_prev, strobe_rise;
	logic [7:0] mem [MEM_DEPTH];
	logic [2:0] lock_bits;
	logic [TIMER_W-1:0] busy_cnt;
	logic busy, erasing, sweep;
	logic [11:0] s_addr, sweep_ptr, last_addr;
	logic [7:0] s_din, last_data, reply_byte;
	logic prog_enabled, head_toggle, full_toggle, head_evt, full_evt, ea_caught;
	logic [23:0] head_word;
	logic [31:0] full_word;
	logic head_s1, head_s2, head_s3, full_s1, full_s2, full_s3;
	logic [1:0] rst_age;
	// decoded start of one operation
	logic next_write, next_erase, write_refused;
	logic [2:0] next_lock;
	logic [11:0] next_addr;
	logic [7:0] next_data;
	logic [TIMER_W-1:0] next_time;
	// the external_access_high_voltage_pin input stands for the pin level and 12 V detect
	// every pin is foreign to ref_clk: two flops before any logic looks at it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1 <= SYNC_RESET; // a zero strobe here would fake an edge after release
			pin_s2 <= SYNC_RESET;
		end else begin
			pin_s1 <= {session_reset, address_in, data_in, mode_sel_c, mode_sel_d, mode_sel_e,
				signature_select_low_a, signature_select_low_b,
				external_access_high_voltage_pin, latch_enable_program_strobe,
				external_access_high_voltage_pin, 1'b0};
			pin_s2 <= pin_s1;
		end
	end
	assign {s_session, s_addr, s_din, s_mode, s_hv, s_strobe, s_ea} = pin_s2[SYNC_W-1:1];
	// strobe edge: the action starts when the strobe returns high
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			strobe_prev <= 1'b1;
		end else begin
			strobe_prev <= s_strobe;
		end
	end
	assign strobe_rise = s_strobe & ~strobe_prev;
	// link domain; toggles come back through three flops, the third only for the edge
	serial_link_shifter link (
		.sck(sck),
		.rst_n(rst_n),
		.mosi(mosi),
		.reply_byte(reply_byte),
		.miso(miso),
		.head_word(head_word),
		.head_toggle(head_toggle),
		.full_word(full_word),
		.full_toggle(full_toggle)
	);
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			{head_s1, head_s2, head_s3} <= 3'h0;
			{full_s1, full_s2, full_s3} <= 3'h0;
		end else begin
			{head_s1, head_s2, head_s3} <= {head_toggle, head_s1, head_s2};
			{full_s1, full_s2, full_s3} <= {full_toggle, full_s1, full_s2};
		end
	end
	assign head_evt = head_s2 ^ head_s3;
	assign full_evt = full_s2 ^ full_s3;
	// decode one parallel strobe or one complete serial instruction into an operation
	always_comb begin
		next_write = 1'b0;
		next_erase = 1'b0;
		next_lock = 3'h0;
		next_addr = s_addr;
		next_data = s_din;
		next_time = TIMER_W'(PAR_WRITE_TIME);
		if (s_session && !busy && s_hv && strobe_rise) begin
			case (s_mode)
				MODE_WRITE_CODE: next_write = 1'b1;
				MODE_WRITE_LOCK1: next_lock = 3'h1;
				MODE_WRITE_LOCK2: next_lock = 3'h2;
				MODE_WRITE_LOCK3: next_lock = 3'h4;
				MODE_CHIP_ERASE: next_erase = 1'b1;
				default: next_write = 1'b0;
			endcase
		end else if (s_session && prog_enabled && !busy && full_evt) begin
			next_addr = {full_word[19:16], full_word[15:8]};
			next_data = full_word[7:0];
			next_time = TIMER_W'(SER_WRITE_TIME);
			if (full_word[31:24] == SER_OP_WRITE) begin
				next_write = 1'b1;
			end else if (full_word[31:24] == SER_OP_SPECIAL) begin
				if (full_word[23:21] == SER_ERASE_B2_TOP) begin
					next_erase = 1'b1;
				end else if (full_word[23:18] == SER_LOCK_B2_TOP) begin
					next_lock = (full_word[17:16] == 2'h3) ? 3'h7 :
						(full_word[17:16] == 2'h2) ? 3'h3 : {2'h0, full_word[16]};
				end
			end
		end
		if (next_erase) begin
			next_time = TIMER_W'(ERASE_TIME);
		end
	end
	assign write_refused = next_write & lock_bits[0];
	// one timer serves byte writes and erase; progress output follows it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			erasing <= 1'b0;
			busy_cnt <= '0;
		end else if ((next_write && !write_refused) || next_erase || next_lock != 3'h0) begin
			busy <= 1'b1;
			erasing <= next_erase;
			busy_cnt <= next_time - TIMER_W'(1);
		end else if (busy && busy_cnt == '0) begin
			busy <= 1'b0;
			erasing <= 1'b0;
		end else if (busy) begin
			busy_cnt <= busy_cnt - TIMER_W'(1);
		end
	end
	// progress output: low while busy, idles high
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			program_progress_output <= 1'b1;
		end else begin
			program_progress_output <= ~busy;
		end
	end
	// last byte written, kept for data polling
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			last_addr <= 12'h0;
			last_data <= 8'h0;
		end else if (next_write && !write_refused) begin
			last_addr <= next_addr;
			last_data <= next_data;
		end
	end
	// nonvolatile lock bits modelled as flops; erase also clears them
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lock_bits <= LOCK_RESET;
		end else if (next_erase) begin
			lock_bits <= LOCK_RESET;
		end else begin
			lock_bits <= lock_bits | next_lock;
		end
	end
	// erase sweep writes ff one address per cycle, far inside the erase time
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sweep <= 1'b0;
			sweep_ptr <= 12'h0;
		end else if (next_erase) begin
			sweep <= 1'b1;
			sweep_ptr <= 12'h0;
		end else if (sweep) begin
			sweep <= (sweep_ptr != 12'hfff);
			sweep_ptr <= sweep_ptr + 12'h1;
		end
	end
	// array has no reset; contents are only defined after an erase or a write
	always_ff @(posedge ref_clk) begin
		if (sweep) begin
			mem[sweep_ptr] <= ERASED_VALUE;
		end else if (next_write && !write_refused) begin
			mem[next_addr] <= next_data;
		end
	end
	// enable flag lives only while session reset stays high
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prog_enabled <= 1'b0;
		end else if (!s_session) begin
			prog_enabled <= 1'b0;
		end else if (full_evt && full_word[31:24] == SER_OP_SPECIAL
			&& full_word[23:16] == SER_ENABLE_B2) begin
			prog_enabled <= 1'b1;
		end
	end
	// fourth-byte answer, settled right after the third byte lands
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reply_byte <= 8'h0;
		end else if (head_evt) begin
			if (head_word[23:16] == SER_OP_SPECIAL && head_word[15:8] == SER_ENABLE_B2) begin
				reply_byte <= SER_ENABLE_ECHO;
			end else if (head_word[23:16] != SER_OP_READ || !prog_enabled) begin
				reply_byte <= 8'h0;
			end else if (erasing) begin
				reply_byte <= ERASE_READ_VALUE;
			end else if (busy && {head_word[11:8], head_word[7:0]} == last_addr) begin
				reply_byte <= {~last_data[7], last_data[6:0]};
			end else if (verify_block) begin
				reply_byte <= BLOCKED_READ_VALUE;
			end else begin
				reply_byte <= mem[{head_word[11:8], head_word[7:0]}];
			end
		end
	end
	// parallel readback; lock state always readable, code only when verify allowed
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_out <= 8'h0;
			data_oe <= 1'b0;
		end else begin
			data_oe <= s_session && !s_hv && (s_mode == MODE_READ_CODE
				|| s_mode == MODE_READ_LOCK || s_mode == MODE_SIGNATURE);
			if (s_mode == MODE_READ_LOCK) begin
				data_out <= 8'(lock_bits) << LOCK_RD_POS;
			end else if (s_mode == MODE_SIGNATURE) begin
				data_out <= (s_addr == SIG_ADDR_MAKER) ? MAKER_CODE :
					(s_addr == SIG_ADDR_DEV_A) ? DEVICE_CODE_A :
					(s_addr == SIG_ADDR_DEV_B) ? DEVICE_CODE_B : 8'h0;
			end else if (busy && s_addr == last_addr) begin
				data_out <= {~last_data[7], last_data[6:0]};
			end else if (lock_bits[1:0] == 2'h3) begin
				data_out <= BLOCKED_READ_VALUE;
			end else begin
				data_out <= mem[s_addr];
			end
		end
	end
	// protection levels; the pin is caught on the third edge after release, once synced
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_age <= 2'h0;
			ea_caught <= 1'b0;
		end else if (rst_age != 2'h3) begin
			rst_age <= rst_age + 2'h1;
			if (rst_age == 2'h2) begin
				ea_caught <= s_ea;
			end
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lock_state <= LOCK_RESET;
			table_read_block <= 1'b0;
			verify_block <= 1'b0;
			external_exec_block <= 1'b0;
			external_access_latched <= 1'b0;
		end else begin
			lock_state <= lock_bits;
			table_read_block <= lock_bits[0];
			verify_block <= lock_bits[0] & lock_bits[1];
			external_exec_block <= &lock_bits;
			external_access_latched <= lock_bits[0] ? ea_caught : s_ea;
		end
	end
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_busy_after_strobe;
		(next_write && !write_refused) |=> busy ##1 !program_progress_output;
	endproperty
	a_busy_after_strobe: assert property (p_busy_after_strobe) else $error("no busy after write");
	property p_timer_bound;
		busy |-> busy_cnt < TIMER_W'(ERASE_TIME);
	endproperty
	a_timer_bound: assert property (p_timer_bound) else $error("timer beyond limit");
	property p_par_poll;
		(busy && !next_write && s_mode == MODE_READ_CODE && s_addr == last_addr)
			|=> data_out[7] == ~last_data[7];
	endproperty
	a_par_poll: assert property (p_par_poll) else $error("poll bit wrong");
	property p_erase_read_zero;
		(head_evt && erasing && head_word[23:16] == SER_OP_READ && prog_enabled)
			|=> reply_byte == ERASE_READ_VALUE;
	endproperty
	a_erase_read_zero: assert property (p_erase_read_zero) else $error("erase read not 00");
	property p_sweep_ff;
		sweep |=> mem[$past(sweep_ptr)] == ERASED_VALUE;
	endproperty
	a_sweep_ff: assert property (p_sweep_ff) else $error("erase left data");
	property p_locked_no_write;
		(lock_bits[0] && next_write && !busy) |=> !busy;
	endproperty
	a_locked_no_write: assert property (p_locked_no_write) else $error("locked write ran");
	property p_enable_first;
		(full_evt && !prog_enabled && !busy) |=> !busy;
	endproperty
	a_enable_first: assert property (p_enable_first) else $error("serial op before enable");
	property p_verify_blocked;
		(lock_bits[1:0] == 2'h3 && !busy && s_mode == MODE_READ_CODE)
			|=> data_out == BLOCKED_READ_VALUE;
	endproperty
	a_verify_blocked: assert property (p_verify_blocked) else $error("verify leaked");
	property p_enable_echo;
		(head_evt && head_word[23:16] == SER_OP_SPECIAL && head_word[15:8] == SER_ENABLE_B2)
			|=> reply_byte == SER_ENABLE_ECHO;
	endproperty
	a_enable_echo: assert property (p_enable_echo) else $error("bad enable echo");
	// one cycle only: a lock written in the next cycle may raise protection legally after
	property p_no_lock_free;
		(lock_bits == 3'h0) |=> !table_read_block && !verify_block && !external_exec_block;
	endproperty
	a_no_lock_free: assert property (p_no_lock_free) else $error("protection without lock");
	c_par_write: cover property (next_write && !write_refused ##1 busy);
	c_erase: cover property (next_erase ##1 sweep);
	c_enable: cover property (!prog_enabled ##1 prog_enabled);
	c_ser_read: cover property (head_evt && head_word[23:16] == SER_OP_READ);
endmodule
`default_nettype wire

// ### isp_host_model.sv
`default_nettype none
// serial programmer on the far side of the link, one frame per request
module isp_host_model (
	input wire logic go,
	input wire logic [31:0] cmd,
	input wire logic miso,
	output logic sck,
	output logic mosi,
	output logic [7:0] reply,
	output logic done
);
	timeunit 1ns;
	timeprecision 100ps;
	logic link_clk;
	// 32 ns link clock, offset so its edges never meet ref_clk edges
	initial begin
		link_clk = 1'b0;
		#7;
		forever #16 link_clk = ~link_clk;
	end
	// sck high one link period, low two: 96 ns stays below a sixteenth of ref_clk
	initial begin
		int i;
		sck = 1'b0;
		mosi = 1'b0;
		reply = 8'h00;
		done = 1'b0;
		forever begin
			@(posedge link_clk);
			if (go && !done) begin
				for (i = 31; i >= 0; i--) begin
					mosi = cmd[i];
					@(posedge link_clk);
					sck = 1'b1;
					if (i < 8) reply = {reply[6:0], miso};
					@(posedge link_clk);
					sck = 1'b0;
					@(posedge link_clk);
				end
				// idle line shows the inverse, sck stands still between frames
				mosi = ~mosi;
				done = 1'b1;
			end else if (!go) begin
				done = 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ### flash_program_lock_interface_tb_top.sv
`default_nettype none
module flash_program_lock_interface_tb_top
	import flash_lock_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int PW_T = 20;
	localparam int SW_T = 1000;
	localparam int ER_T = 5000;
	localparam logic [7:0] MAKER = 8'h96; // arbitrary value
	localparam logic [7:0] DEV_A = 8'h2d; // arbitrary value
	localparam logic [7:0] DEV_B = 8'hc3; // arbitrary value
	typedef struct {logic wr; logic [4:0] m; logic [11:0] a; logic [7:0] d;} row_type;
	// writes are read back as code; signature rows are plain reads
	row_type rows [6] = '{'{1'b1, MODE_WRITE_CODE, 12'h000, 8'h5a},
		'{1'b1, MODE_WRITE_CODE, 12'hfff, 8'h81}, '{1'b1, MODE_WRITE_CODE, 12'h7ff, 8'h00},
		'{1'b0, MODE_SIGNATURE, SIG_ADDR_MAKER, MAKER}, '{1'b0, MODE_SIGNATURE, SIG_ADDR_DEV_A, DEV_A},
		'{1'b0, MODE_SIGNATURE, SIG_ADDR_DEV_B, DEV_B}};
	logic ref_clk = 1'b0;
	logic rst_n, sess, hv, strobe, go, oe, prog, miso, sck, mosi, done, trb, vb, eeb, eal;
	logic [4:0] mode;
	logic [11:0] addr;
	logic [7:0] din, dout, reply, q;
	logic [31:0] cmd;
	logic [2:0] lock;
	int failures = 0;
	int n_compared = 0;
	int cyc = 0;
	int n;
	always #2 ref_clk = ~ref_clk;
	flash_program_lock_interface #(.PAR_WRITE_TIME(PW_T), .SER_WRITE_TIME(SW_T),
		.ERASE_TIME(ER_T), .MAKER_CODE(MAKER), .DEVICE_CODE_A(DEV_A), .DEVICE_CODE_B(DEV_B)) dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .session_reset(sess), .address_in(addr),
		.data_in(din), .mode_sel_c(mode[4]), .mode_sel_d(mode[3]), .mode_sel_e(mode[2]),
		.signature_select_low_a(mode[1]), .signature_select_low_b(mode[0]),
		.external_access_high_voltage_pin(hv), .latch_enable_program_strobe(strobe),
		.sck(sck), .mosi(mosi), .data_out(dout), .data_oe(oe), .program_progress_output(prog),
		.miso(miso), .lock_state(lock), .table_read_block(trb), .verify_block(vb),
		.external_exec_block(eeb), .external_access_latched(eal));
	isp_host_model host (.go(go), .cmd(cmd), .miso(miso), .sck(sck), .mosi(mosi),
		.reply(reply), .done(done));
	task close_out;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task check(string name, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task par_set(logic [4:0] m, logic [11:0] a, logic [7:0] d, logic v);
		@(posedge ref_clk);
		mode <= m;
		addr <= a;
		din <= d;
		@(posedge ref_clk);
		hv <= v;
	endtask
	// address, data, mode, then voltage are already set; one low pulse of 240 ns
	task pulse;
		repeat (4) @(posedge ref_clk);
		strobe <= 1'b0;
		repeat (60) @(posedge ref_clk);
		strobe <= 1'b1;
	endtask
	// length of the busy phase; zero when the request was refused
	task wait_ready(output int b);
		int k;
		b = 0;
		k = 0;
		while (prog !== 1'b0 && k < 30) begin
			@(posedge ref_clk);
			k++;
		end
		while (prog === 1'b0 && b < ER_T + 100) begin
			@(posedge ref_clk);
			b++;
		end
	endtask
	task par_prog(logic [4:0] m, logic [11:0] a, logic [7:0] d, output int b);
		par_set(m, a, d, 1'b1);
		pulse();
		wait_ready(b);
	endtask
	task par_read(logic [4:0] m, logic [11:0] a, output logic [7:0] r);
		par_set(m, a, 8'h00, 1'b0);
		repeat (8) @(posedge ref_clk);
		r = dout;
	endtask
	// one whole frame; done is held until go drops, so wait for its release too
	task ser(logic [31:0] c, output logic [7:0] r);
		int k;
		@(posedge ref_clk);
		cmd <= c;
		go <= 1'b1;
		k = 0;
		while (done !== 1'b1 && k < 1000) begin
			@(posedge ref_clk);
			k++;
		end
		go <= 1'b0;
		r = reply;
		while (done !== 1'b0 && k < 1100) begin
			@(posedge ref_clk);
			k++;
		end
	endtask
	// a hang anywhere ends the run as a mismatch
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 60000) begin
			failures++;
			close_out();
		end
	end
	initial begin
		rst_n = 1'b0;
		sess = 1'b0;
		hv = 1'b0;
		strobe = 1'b1;
		go = 1'b0;
		mode = MODE_READ_CODE;
		addr = 12'h000;
		din = 8'h00;
		cmd = 32'h0;
		repeat (5) @(posedge ref_clk);
		check("lock_reset", lock, 3'h0);
		check("protect_reset", {trb, vb, eeb}, 3'h0);
		check("progress_reset", prog, 1'b1);
		rst_n <= 1'b1;
		sess <= 1'b1;
		repeat (4) @(posedge ref_clk);
		$display("test reset done");
		par_prog(MODE_CHIP_ERASE, 12'h000, 8'h00, n);
		check("erase_len", n >= ER_T - 3 && n <= ER_T + 3, 1'b1);
		par_read(MODE_READ_CODE, 12'h000, q);
		check("erased", q, ERASED_VALUE);
		$display("test erase done");
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				par_prog(rows[i].m, rows[i].a, rows[i].d, n);
				check("write_len", n >= PW_T - 3 && n <= PW_T + 3, 1'b1);
				par_read(MODE_READ_CODE, rows[i].a, q);
			end else begin
				par_read(rows[i].m, rows[i].a, q);
			end
			check("read_data", q, rows[i].d);
			check("data_oe", oe, 1'b1);
		end
		$display("test rows done");
		par_set(MODE_WRITE_CODE, 12'h010, 8'h3c, 1'b1);
		pulse();
		par_set(MODE_READ_CODE, 12'h010, 8'h00, 1'b0);
		repeat (6) @(posedge ref_clk);
		check("busy_low", prog, 1'b0);
		check("poll_bit7", dout[7], 1'b1);
		wait_ready(n);
		repeat (8) @(posedge ref_clk);
		check("poll_done", dout, 8'h3c);
		$display("test polling done");
		par_set(MODE_READ_LOCK, 12'h000, 8'h00, 1'b1);
		repeat (6) @(posedge ref_clk);
		check("ea_live", eal, 1'b1);
		par_prog(MODE_WRITE_LOCK1, 12'h000, 8'h00, n);
		par_read(MODE_READ_LOCK, 12'h000, q);
		check("lock_read1", q[LOCK_RD_POS +: 3], 3'h1);
		check("protect1", {trb, vb, eeb}, 3'h4);
		par_set(MODE_READ_LOCK, 12'h000, 8'h00, 1'b1);
		repeat (6) @(posedge ref_clk);
		check("ea_latched", eal, 1'b0);
		par_prog(MODE_WRITE_CODE, 12'h020, 8'h11, n);
		check("locked_write", n, 0);
		par_prog(MODE_WRITE_LOCK2, 12'h000, 8'h00, n);
		check("protect2", {trb, vb, eeb}, 3'h6);
		par_read(MODE_READ_CODE, 12'h000, q);
		check("verify_blocked", q, BLOCKED_READ_VALUE);
		par_prog(MODE_WRITE_LOCK3, 12'h000, 8'h00, n);
		check("protect3", {trb, vb, eeb}, 3'h7);
		par_read(MODE_READ_LOCK, 12'h000, q);
		check("lock_read3", q[LOCK_RD_POS +: 3], 3'h7);
		par_prog(MODE_CHIP_ERASE, 12'h000, 8'h00, n);
		check("locks_cleared", lock, 3'h0);
		$display("test locks done");
		ser(32'h40000577, q); // dropped: no enable yet; session long settled
		check("no_enable_reply", q, 8'h00);
		ser({SER_OP_SPECIAL, SER_ENABLE_B2, 16'h0000}, q);
		check("enable_echo", q, SER_ENABLE_ECHO);
		ser(32'h20000500, q);
		check("write_refused", q, ERASED_VALUE);
		ser(32'h40000577, q);
		ser(32'h20000500, q);
		check("ser_poll", q, 8'hf7);
		repeat (SW_T + 100) @(posedge ref_clk);
		ser(32'h20000500, q);
		check("ser_read", q, 8'h77);
		ser({SER_OP_SPECIAL, 8'h80, 16'h0000}, q);
		ser(32'h20000500, q);
		check("erase_read", q, ERASE_READ_VALUE);
		repeat (ER_T) @(posedge ref_clk);
		ser(32'h20000500, q);
		check("ser_erased", q, ERASED_VALUE);
		ser({SER_OP_SPECIAL, 8'he2, 16'h0000}, q); // lock bits one and two
		repeat (8) @(posedge ref_clk);
		check("ser_lock", lock, 3'h3);
		check("ser_protect", {trb, vb, eeb}, 3'h6);
		$display("test serial done");
		sess <= 1'b0;
		repeat (8) @(posedge ref_clk);
		sess <= 1'b1;
		repeat (8) @(posedge ref_clk);
		ser(32'h20000500, q);
		check("session_ended", q, 8'h00);
		$display("test session end done");
		close_out();
	end
endmodule
`default_nettype wire
